// >>> fpk_keypad.sv
// Keypad model: a person pressing one debounced key at a time
// Assumes the panel logic samples key levels on the rising edge of clk
`timescale 1ns/100ps
module fpk_keypad
   import fpk_pkg::*;
(
   // Clock
   input wire logic clk,
   // Key levels
   output fpk_keys_t keys
);
   initial keys = '0;

   // ==========================================
   // Press, hold, release, then idle two cycles
   task automatic press(input int k, input int hold);
      begin
         @(posedge clk);
         keys[k] <= 1'b1;
         repeat (hold) @(posedge clk);
         keys[k] <= 1'b0;
         repeat (2) @(posedge clk);
      end
   endtask
endmodule

// >>> fpk_pkg.sv
// Package for the front-panel key and menu controller
// Assumes a single 100 MHz clock domain and an AXI4-Lite register master
package fpk_pkg;

   // ==========================================
   // Register offsets (byte addresses)
   localparam logic [7:0] FPK_CTRL_OFF = 8'h00;
   localparam logic [7:0] FPK_STAT_OFF = 8'h04;
   localparam logic [7:0] FPK_VAL_OFF = 8'h08;
   localparam logic [7:0] FPK_DISP_OFF = 8'h0c;

   // ==========================================
   // Control field positions
   localparam int FPK_CTRL_LATCH_BIT = 0;
   localparam int FPK_CTRL_SUPPLY_BIT = 1;
   localparam int FPK_CTRL_REMOTE_BIT = 2;
   localparam logic [2:0] FPK_CTRL_RST = 3'h2;

   // ==========================================
   // Timing and counts
   localparam int FPK_CLK_MHZ = 100;
   localparam int FPK_BLINK_MS = 250;
   localparam int FPK_BLINK_CYC = FPK_BLINK_MS * 1000 * FPK_CLK_MHZ;
   localparam int FPK_BEEP_MS = 100;
   localparam int FPK_BEEP_CYC = FPK_BEEP_MS * 1000 * FPK_CLK_MHZ;
   localparam int FPK_TEST_MS = 2000;
   localparam int FPK_TEST_CYC = FPK_TEST_MS * 1000 * FPK_CLK_MHZ;
   localparam logic [2:0] FPK_SAVE_BEEPS = 3'h3;
   localparam int FPK_NMENU = 4;
   localparam int FPK_NITEM = 3;
   localparam logic [15:0] FPK_VAL_MIN = 16'h0000;
   localparam logic [15:0] FPK_VAL_MAX = 16'h03e8;
   localparam logic [15:0] FPK_VAL_STEP = 16'h0001;
   localparam logic [15:0] FPK_VAL_RST = 16'h0064;

   // ==========================================
   // Display codes
   typedef enum logic [3:0] {
      FPK_SHOW_NORMAL, FPK_SHOW_MENUS, FPK_SHOW_MENU, FPK_SHOW_ITEM,
      FPK_SHOW_SAVING, FPK_SHOW_EMERG, FPK_SHOW_TEST, FPK_SHOW_ERROR
   } fpk_show_t;

   // Key group
   typedef struct packed {
      logic emerg;
      logic test;
      logic rst;
      logic mute;
      logic factory;
      logic menu;
      logic sel;
      logic up;
      logic down;
   } fpk_keys_t;

   // Damper command
   typedef struct packed {
      logic active;
      logic supply_open;
      logic supply_close;
      logic exhaust_open;
      logic exhaust_close;
   } fpk_damper_t;

endpackage

// >>> fpk_tb.sv
// Self-checking bench for the key and menu controller
// Assumes fpk_pkg, fpk_top and fpk_keypad are compiled first
`timescale 1ns/100ps
`define CHK(nm, e, a) begin comparisons++; if ((a) !== (e)) begin fails++; $display("BAD %s exp %0h got %0h", nm, e, a); end end
module testbench
   import fpk_pkg::*;
;
   localparam int K_DOWN = 0;
   localparam int K_UP = 1;
   localparam int K_SEL = 2;
   localparam int K_MENU = 3;
   localparam int K_FACT = 4;
   localparam int K_MUTE = 5;
   localparam int K_RST = 6;
   localparam int K_TEST = 7;
   localparam int K_EMERG = 8;
   localparam logic [15:0] K_VER = 16'h0123;
   logic clk, rst_b, target_pos, press_alarm, press_normal, error_in;
   fpk_keys_t keys;
   logic alarm_lamp, caution_lamp, mute_lamp, buzzer, alarm_relay, nv_store;
   fpk_show_t show;
   logic [1:0] menu_idx, item_idx, rsp, cb, m_item;
   logic [15:0] line2_val;
   fpk_damper_t damper;
   logic [7:0] s_awaddr, s_araddr;
   logic [31:0] s_wdata, s_rdata, rd, seed;
   logic [3:0] s_wstrb;
   logic [1:0] s_bresp, s_rresp;
   logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
   logic s_arvalid, s_arready, s_rvalid, s_rready, bz_q, al_q;
   int fails, comparisons, bz_rise, al_rise, nv_cnt, m_val, i;

   fpk_top #(.BLINK_CYC(4), .BEEP_CYC(3), .TEST_CYC(20), .SW_VERSION(K_VER)) u_fpk_top (.clk(clk), .rst_b(rst_b),
      .keys(keys),
      .target_pos(target_pos), .press_alarm(press_alarm), .press_normal(press_normal), .error_in(error_in),
      .alarm_lamp(alarm_lamp), .caution_lamp(caution_lamp), .mute_lamp(mute_lamp), .buzzer(buzzer),
      .alarm_relay(alarm_relay), .show(show), .menu_idx(menu_idx), .item_idx(item_idx), .line2_val(line2_val),
      .damper(damper), .nv_store(nv_store), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
      .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
      .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
      .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready));
   fpk_keypad u_fpk_keypad (.clk(clk), .keys(keys));

   // ==========================================
   // Clock and edge counters
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      bz_q <= buzzer;
      al_q <= alarm_lamp;
      if (buzzer === 1'b1 && bz_q === 1'b0)
         bz_rise++;
      if (alarm_lamp === 1'b1 && al_q === 1'b0)
         al_rise++;
      if (nv_store === 1'b1)
         nv_cnt++;
   end

   // ==========================================
   // Helpers
   function automatic logic [31:0] xs(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
   endfunction
   task automatic pr(input int k);
      seed = xs(seed);
      u_fpk_keypad.press(k, 1 + int'(seed[1:0]));
      #1;
   endtask
   task automatic plant(input logic a, input logic n);
      @(posedge clk);
      press_alarm <= a;
      press_normal <= n;
      repeat (3) @(posedge clk);
      #1;
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      s_awaddr <= a;
      s_wdata <= d;
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (s_awready === 1'b1)
            s_awvalid <= 1'b0;
         if (s_wready === 1'b1)
            s_wvalid <= 1'b0;
      end
      while (s_bvalid !== 1'b1);
      r = s_bresp;
      s_bready <= 1'b0;
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      s_araddr <= a;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (s_arready === 1'b1)
            s_arvalid <= 1'b0;
      end
      while (s_rvalid !== 1'b1);
      d = s_rdata;
      r = s_rresp;
      s_rready <= 1'b0;
   endtask
   task automatic test_done;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ==========================================
   // Watchdog, well above the expected thousand or so cycles
   initial
   begin
      repeat (20000) @(posedge clk);
      fails++;
      test_done;
   end

   // ==========================================
   // Main sequence
   initial
   begin
      {rst_b, target_pos, press_alarm, press_normal, error_in} = '0;
      {s_awaddr, s_araddr, s_wdata, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
      s_wstrb = 4'hf;
      {fails, comparisons, bz_rise, al_rise, nv_cnt} = '0;
      seed = 32'd63607;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      #1;
      `CHK("show", FPK_SHOW_NORMAL, show)
      `CHK("val", FPK_VAL_RST, line2_val)
      axr(FPK_CTRL_OFF, rd, rsp);
      `CHK("ctrl", 32'h2, rd)
      axr(8'h40, rd, rsp);
      `CHK("rresp", 2'h2, rsp)
      axw(8'h44, 32'h0, rsp);
      `CHK("bresp", 2'h2, rsp)
      $display("done registers");
      for (i = 0; i < 4; i++)
      begin
         cb = i[1:0];
         axw(FPK_CTRL_OFF, {30'h0, cb[1], 1'b0}, rsp);
         target_pos <= cb[0];
         al_rise = 0;
         bz_rise = 0;
         pr(K_EMERG);
         wait (alarm_lamp === 1'b1);
         #1;
         `CHK("show", FPK_SHOW_EMERG, show)
         `CHK("damper", {1'b1, cb[1] & cb[0], cb[1] & ~cb[0], ~cb[1] & ~cb[0], ~cb[1] & cb[0]}, damper)
         repeat (20) @(posedge clk);
         #1;
         `CHK("blink", 1'b1, al_rise > 1 && bz_rise > 1)
         pr(cb[0] ? K_EMERG : K_RST);
         `CHK("show", FPK_SHOW_NORMAL, show)
         `CHK("damper", 5'h0, damper)
      end
      $display("done emergency");
      pr(K_TEST);
      `CHK("show", FPK_SHOW_TEST, show)
      `CHK("ver", K_VER, line2_val)
      repeat (30) @(posedge clk);
      #1;
      `CHK("show", FPK_SHOW_NORMAL, show)
      $display("done self test");
      m_val = FPK_VAL_RST;
      pr(K_MENU);
      `CHK("show", FPK_SHOW_MENUS, show)
      pr(K_DOWN);
      `CHK("menu", 2'h1, menu_idx)
      pr(K_UP);
      pr(K_UP);
      `CHK("menu", 2'h0, menu_idx)
      pr(K_SEL);
      `CHK("show", FPK_SHOW_MENU, show)
      `CHK("item", 2'h0, item_idx)
      for (i = 1; i <= 3; i++)
      begin
         pr(K_DOWN);
         m_item = (i > 2) ? 2'h2 : i[1:0];
         `CHK("item", m_item, item_idx)
      end
      pr(K_UP);
      pr(K_UP);
      pr(K_SEL);
      `CHK("show", FPK_SHOW_ITEM, show)
      `CHK("val", m_val[15:0], line2_val)
      pr(K_UP);
      m_val++;
      `CHK("val", m_val[15:0], line2_val)
      pr(K_FACT);
      `CHK("val", m_val[15:0], line2_val)
      `CHK("show", FPK_SHOW_ITEM, show)
      pr(K_MENU);
      `CHK("show", FPK_SHOW_MENU, show)
      pr(K_SEL);
      m_val = FPK_VAL_RST;
      `CHK("val", m_val[15:0], line2_val)
      repeat (m_val + 1) pr(K_DOWN);
      m_val = 0;
      `CHK("val", m_val[15:0], line2_val)
      nv_cnt = 0;
      bz_rise = 0;
      pr(K_SEL);
      `CHK("show", FPK_SHOW_SAVING, show)
      `CHK("store", 1, nv_cnt)
      repeat (30) @(posedge clk);
      #1;
      `CHK("beeps", 3, bz_rise)
      `CHK("show", FPK_SHOW_MENU, show)
      pr(K_SEL);
      `CHK("val", m_val[15:0], line2_val)
      pr(K_MENU);
      pr(K_MENU);
      `CHK("show", FPK_SHOW_MENUS, show)
      pr(K_MENU);
      `CHK("show", FPK_SHOW_NORMAL, show)
      $display("done menus");
      plant(1'b1, 1'b0);
      `CHK("buzzer", 1'b1, buzzer)
      plant(1'b0, 1'b1);
      `CHK("buzzer", 1'b0, buzzer)
      plant(1'b1, 1'b0);
      pr(K_MUTE);
      `CHK("buzzer", 1'b0, buzzer)
      plant(1'b0, 1'b1);
      pr(K_MUTE);
      `CHK("mute", 1'b1, mute_lamp)
      plant(1'b1, 1'b0);
      `CHK("buzzer", 1'b0, buzzer)
      plant(1'b0, 1'b1);
      $display("done mute");
      axw(FPK_CTRL_OFF, 32'h3, rsp);
      plant(1'b1, 1'b0);
      plant(1'b0, 1'b0);
      pr(K_RST);
      `CHK("lamp", 2'h3, {alarm_lamp, alarm_relay})
      plant(1'b0, 1'b1);
      pr(K_RST);
      `CHK("lamp", 2'h0, {alarm_lamp, alarm_relay})
      @(posedge clk);
      error_in <= 1'b1;
      @(posedge clk);
      error_in <= 1'b0;
      axr(FPK_STAT_OFF, rd, rsp);
      `CHK("err", 1'b1, rd[5])
      `CHK("show", FPK_SHOW_ERROR, show)
      pr(K_RST);
      axr(FPK_STAT_OFF, rd, rsp);
      `CHK("err", 1'b0, rd[5])
      axw(FPK_CTRL_OFF, 32'h6, rsp);
      #1;
      `CHK("caution", 1'b1, caution_lamp)
      $display("done alarms");
      test_done;
   end
endmodule

// >>> fpk_top.sv
// Front-panel key decoder, menu walker and emergency outputs
// Keys arrive debounced and synchronous to clk; registers on AXI4-Lite
//
// Summary of operation
// RL1 - Factory test key is ignored entirely.
// RL2 - Emergency, positive target: supply opens, or exhaust closes.
// RL3 - Emergency, negative target: supply closes, or exhaust opens.
// RL4 - Emergency flashes message, blinks alarm lamp, pulses buzzer.
// RL5 - Emergency or reset key during emergency returns to normal.
// RL6 - Test key runs self-test showing version, control target, exercising outputs.
// RL7 - Latched alarms clear on reset only once pressure is normal.
// RL8 - Reset key clears a shown error message.
// RL9 - Mute while buzzer sounds silences it immediately.
// RL10 - Mute while silent and mute lamp off disables the buzzer.
// RL11 - Mute lamp lit while buzzer disabled; buzzer then silent.
// RL12 - Menu key in normal mode enters main menu listing.
// RL13 - Menu key moves up one level, discarding edited value.
// RL14 - Menu key at main level restores normal display.
// RL15 - Select enters highlighted menu, or opens highlighted item.
// RL16 - Select while editing stores value, then moves up one level.
// RL17 - Storing gives three beeps, saving message, then title and item.
// RL18 - Arrows step choices when browsing, change value when editing.
// RL19 - Menu: title then item; item: name then value.
// RL20 - Targets menu order: control, reduced-occupancy, minimum limit.
// RL21 - Alarm-follow buzzer sounds until mute or pressure normal.
// RL22 - Caution lamp lit while running on remote target.
// RL23 - Each key press gives exactly one step; holds do not repeat.
// RL24 - Arrow step changes value by one step, saturating at limits.
`timescale 1ns/100ps
module fpk_top
   import fpk_pkg::*;
#(
   parameter int BLINK_CYC = FPK_BLINK_CYC,
   parameter int BEEP_CYC = FPK_BEEP_CYC,
   parameter int TEST_CYC = FPK_TEST_CYC,
   parameter logic [15:0] SW_VERSION = 16'h0001
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Keypad (level, debounced)
   input wire fpk_keys_t keys,
   // Plant status
   input wire logic target_pos,
   input wire logic press_alarm,
   input wire logic press_normal,
   input wire logic error_in,
   // Lamps, buzzer, display, damper
   output logic alarm_lamp,
   output logic caution_lamp,
   output logic mute_lamp,
   output logic buzzer,
   output logic alarm_relay,
   output fpk_show_t show,
   output logic [1:0] menu_idx,
   output logic [1:0] item_idx,
   output logic [15:0] line2_val,
   output fpk_damper_t damper,
   output logic nv_store,
   // AXI4-Lite slave
   input wire logic [7:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [7:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready
);

   typedef enum {ST_NORMAL, ST_MENUS, ST_MENU, ST_ITEM, ST_SAVE, ST_EMERG, ST_TEST} fpk_state_t;

   // ==========================================
   // Key edge detection
   fpk_keys_t keys_r;
   fpk_keys_t press;
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         keys_r <= '0;
      else
         keys_r <= keys;
   end
   assign press = keys & ~keys_r; // [RL23]

   // ==========================================
   // Registers
   logic [2:0] ctrl_r;
   logic [15:0] val_r [FPK_NITEM];
   logic [15:0] edit_r;
   fpk_state_t state_r;
   logic [31:0] tick_r;
   logic blink_r;
   logic [2:0] beeps_r;
   logic [31:0] sub_r;
   logic mute_r, alarm_lat_r, error_r, mute_dis_r;
   logic wr_go;
   logic [7:0] awaddr_r;
   logic aw_have_r, w_have_r;
   logic [31:0] wdata_r;
   logic wstrb0_r, test_late;

   // ==========================================
   // Blink timebase
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         tick_r <= '0;
         blink_r <= 1'b0;
      end
      else if (tick_r >= 32'(BLINK_CYC - 1))
      begin
         tick_r <= '0;
         blink_r <= ~blink_r;
      end
      else
         tick_r <= tick_r + 32'h1;
   end

   // ==========================================
   // Menu and mode state
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_r <= ST_NORMAL;
         menu_idx <= '0;
         item_idx <= '0;
         edit_r <= '0;
         beeps_r <= '0;
         sub_r <= '0;
         nv_store <= 1'b0;
         for (int i = 0; i < FPK_NITEM; i++)
            val_r[i] <= FPK_VAL_RST;
      end
      else
      begin
         nv_store <= 1'b0;
         case (state_r)
            ST_NORMAL:
               if (press.emerg)
                  state_r <= ST_EMERG;
               else if (press.test)
               begin
                  state_r <= ST_TEST; // [RL6]
                  sub_r <= '0;
               end
               else if (press.menu)
               begin
                  state_r <= ST_MENUS; // [RL12]
                  menu_idx <= '0;
               end
            ST_MENUS:
               if (press.menu)
                  state_r <= ST_NORMAL; // [RL14]
               else if (press.sel)
               begin
                  state_r <= ST_MENU; // [RL15]
                  item_idx <= '0; // [RL20]
               end
               else if (press.up && menu_idx != 2'h0)
                  menu_idx <= menu_idx - 2'h1; // [RL18]
               else if (press.down && menu_idx != 2'(FPK_NMENU - 1))
                  menu_idx <= menu_idx + 2'h1; // [RL18]
            ST_MENU:
               if (press.menu)
                  state_r <= ST_MENUS; // [RL13]
               else if (press.sel)
               begin
                  state_r <= ST_ITEM; // [RL15]
                  edit_r <= val_r[item_idx];
               end
               else if (press.up && item_idx != 2'h0)
                  item_idx <= item_idx - 2'h1; // [RL18]
               else if (press.down && item_idx != 2'(FPK_NITEM - 1))
                  item_idx <= item_idx + 2'h1; // [RL18] [RL20]
            ST_ITEM:
               if (press.menu)
                  state_r <= ST_MENU; // [RL13]
               else if (press.sel)
               begin
                  val_r[item_idx] <= edit_r; // [RL16]
                  nv_store <= 1'b1;
                  state_r <= ST_SAVE;
                  beeps_r <= FPK_SAVE_BEEPS; // [RL17]
                  sub_r <= '0;
               end
               else if (press.up)
                  edit_r <= (edit_r >= FPK_VAL_MAX - FPK_VAL_STEP) ? FPK_VAL_MAX : edit_r + FPK_VAL_STEP; // [RL24]
               else if (press.down)
                  edit_r <= (edit_r <= FPK_VAL_MIN + FPK_VAL_STEP) ? FPK_VAL_MIN : edit_r - FPK_VAL_STEP; // [RL24]
            ST_SAVE:
               if (sub_r >= 32'(2 * BEEP_CYC - 1))
               begin
                  sub_r <= '0;
                  beeps_r <= beeps_r - 3'h1;
                  if (beeps_r == 3'h1)
                     state_r <= ST_MENU; // [RL17]
               end
               else
                  sub_r <= sub_r + 32'h1;
            ST_EMERG:
               if (press.emerg || press.rst)
                  state_r <= ST_NORMAL; // [RL5]
            ST_TEST:
               if (sub_r >= 32'(TEST_CYC - 1))
                  state_r <= ST_NORMAL;
               else
                  sub_r <= sub_r + 32'h1;
            default:
               state_r <= ST_NORMAL;
         endcase
      end
   end

   // ==========================================
   // Alarm latch, mute and error message
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         alarm_lat_r <= 1'b0;
         mute_r <= 1'b0;
         error_r <= 1'b0;
         mute_dis_r <= 1'b0;
      end
      else
      begin
         if (press_alarm)
            alarm_lat_r <= 1'b1;
         else if (!ctrl_r[FPK_CTRL_LATCH_BIT] && press_normal)
            alarm_lat_r <= 1'b0; // [RL21]
         else if (press.rst && press_normal)
            alarm_lat_r <= 1'b0; // [RL7]
         if (press.mute)
            mute_r <= 1'b1; // [RL9] [RL10]
         else if (!alarm_lat_r && !press_alarm && !mute_dis_r)
            mute_r <= 1'b0;
         // Disable from silence holds until reset
         if (press.mute && !buzzer && !mute_r)
            mute_dis_r <= 1'b1; // [RL10]
         if (error_in)
            error_r <= 1'b1;
         else if (press.rst)
            error_r <= 1'b0; // [RL8]
      end
   end

   // ==========================================
   // Outputs
   assign test_late = state_r == ST_TEST && sub_r >= 32'(TEST_CYC / 2);
   always_comb
   begin
      alarm_lamp = (state_r == ST_EMERG) ? blink_r : (alarm_lat_r || state_r == ST_TEST); // [RL4]
      alarm_relay = alarm_lat_r;
      caution_lamp = ctrl_r[FPK_CTRL_REMOTE_BIT] || state_r == ST_TEST; // [RL22]
      mute_lamp = mute_r || (state_r == ST_TEST && !test_late); // [RL11]
      if (mute_r)
         buzzer = 1'b0; // [RL11]
      else if (state_r == ST_EMERG)
         buzzer = blink_r; // [RL4]
      else if (state_r == ST_SAVE)
         buzzer = (sub_r < 32'(BEEP_CYC)); // [RL17]
      else if (state_r == ST_TEST)
         buzzer = test_late; // [RL6] [RL11]
      else
         buzzer = alarm_lat_r;
      damper = '0;
      if (state_r == ST_EMERG)
      begin
         damper.active = 1'b1;
         if (ctrl_r[FPK_CTRL_SUPPLY_BIT])
         begin
            damper.supply_open = target_pos; // [RL2]
            damper.supply_close = !target_pos; // [RL3]
         end
         else
         begin
            damper.exhaust_close = target_pos; // [RL2]
            damper.exhaust_open = !target_pos; // [RL3]
         end
      end
      case (state_r)
         ST_MENUS: show = FPK_SHOW_MENUS;
         ST_MENU: show = FPK_SHOW_MENU; // [RL19]
         ST_ITEM: show = FPK_SHOW_ITEM; // [RL19]
         ST_SAVE: show = FPK_SHOW_SAVING;
         ST_EMERG: show = blink_r ? FPK_SHOW_EMERG : FPK_SHOW_NORMAL; // [RL4]
         ST_TEST: show = FPK_SHOW_TEST;
         default: show = error_r ? FPK_SHOW_ERROR : FPK_SHOW_NORMAL;
      endcase
      if (state_r == ST_ITEM)
         line2_val = edit_r;
      else if (state_r == ST_TEST)
         line2_val = test_late ? val_r[0] : SW_VERSION; // [RL6]
      else
         line2_val = val_r[item_idx];
   end

   // ==========================================
   // AXI4-Lite slave
   assign s_awready = !aw_have_r && !s_bvalid;
   assign s_wready = !w_have_r && !s_bvalid;
   assign s_arready = !s_rvalid;
   assign wr_go = aw_have_r && w_have_r;
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= '0;
         wstrb0_r <= 1'b0;
         s_bvalid <= 1'b0;
         s_bresp <= 2'h0;
         ctrl_r <= FPK_CTRL_RST;
      end
      else
      begin
         if (s_awvalid && s_awready)
         begin
            aw_have_r <= 1'b1;
            awaddr_r <= s_awaddr;
         end
         if (s_wvalid && s_wready)
         begin
            w_have_r <= 1'b1;
            wdata_r <= s_wdata;
            wstrb0_r <= s_wstrb[0];
         end
         if (wr_go)
         begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            s_bvalid <= 1'b1;
            s_bresp <= (awaddr_r == FPK_CTRL_OFF) ? 2'h0 : 2'h2;
            if (awaddr_r == FPK_CTRL_OFF && wstrb0_r)
               ctrl_r <= wdata_r[2:0];
         end
         else if (s_bvalid && s_bready)
            s_bvalid <= 1'b0;
      end
   end
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s_rvalid <= 1'b0;
         s_rdata <= '0;
         s_rresp <= 2'h0;
      end
      else if (s_arvalid && s_arready)
      begin
         s_rvalid <= 1'b1;
         s_rresp <= 2'h0;
         case (s_araddr)
            FPK_CTRL_OFF: s_rdata <= {29'h0, ctrl_r};
            FPK_STAT_OFF: s_rdata <= {24'h0, mute_r, alarm_lat_r, error_r, 1'b0, 4'(state_r)};
            FPK_VAL_OFF: s_rdata <= {16'h0, line2_val};
            FPK_DISP_OFF: s_rdata <= {24'h0, 4'(show), menu_idx, item_idx};
            default:
            begin
               s_rdata <= '0;
               s_rresp <= 2'h2;
            end
         endcase
      end
      else if (s_rvalid && s_rready)
         s_rvalid <= 1'b0;
   end

   // ==========================================
   // Checks
   emerg_exit_a: assert property (@(posedge clk) disable iff (!rst_b) // [RL5]
      state_r == ST_EMERG && (press.emerg || press.rst) |=> state_r == ST_NORMAL)
      else $error("emergency not left on key");
   factory_ign_a: assert property (@(posedge clk) disable iff (!rst_b) // [RL1]
      press == fpk_keys_t'(9'h010) |=> $stable(state_r) && $stable(menu_idx))
      else $error("factory key changed state");
   damper_pos_a: assert property (@(posedge clk) disable iff (!rst_b) // [RL2]
      state_r == ST_EMERG && target_pos && ctrl_r[FPK_CTRL_SUPPLY_BIT] |-> damper.supply_open)
      else $error("supply not opened");
   damper_neg_a: assert property (@(posedge clk) disable iff (!rst_b) // [RL3]
      state_r == ST_EMERG && !target_pos && !ctrl_r[FPK_CTRL_SUPPLY_BIT] |-> damper.exhaust_open)
      else $error("exhaust not opened");
   mute_quiet_a: assert property (@(posedge clk) disable iff (!rst_b) // [RL9]
      press.mute |=> !buzzer && mute_lamp)
      else $error("mute did not silence");
   menu_enter_a: assert property (@(posedge clk) disable iff (!rst_b) // [RL12]
      state_r == ST_NORMAL && press == fpk_keys_t'(9'h008) |=> show == FPK_SHOW_MENUS)
      else $error("menu not entered");
   sequence edit_save_s;
      state_r == ST_ITEM && press.sel && !press.menu;
   endsequence
   save_beep_a: assert property (@(posedge clk) disable iff (!rst_b) // [RL16] [RL17]
      edit_save_s |=> nv_store && state_r == ST_SAVE && buzzer == !mute_r)
      else $error("save did not start");
   item_esc_a: assert property (@(posedge clk) disable iff (!rst_b) // [RL13]
      state_r == ST_ITEM && press.menu |=> state_r == ST_MENU && !nv_store)
      else $error("menu key did not escape");
   err_clear_a: assert property (@(posedge clk) disable iff (!rst_b) // [RL8]
      press.rst && !error_in |=> !error_r)
      else $error("error not cleared");
   mute_silent_a: assert property (@(posedge clk) disable iff (!rst_b) // [RL11]
      mute_lamp |-> !buzzer)
      else $error("buzzer sounds under mute lamp");

endmodule
